// ==== dlrpc_pkg.sv ====
// Package for the converter load, reset and pin control block
// Functional notes
// - Load strobe low keeps output latch transparent
// - Output level changes with latch update
// - Reset returns registers, latches to selected level
// - Five address bits fully decoded to register
// - General pin open-drain: pull low or release
// - Reset select sets post-reset output level
// - Clear grounds outputs; connect needs strobe low
// - Data format select; commands always binary
// - Busy pulled low while correction engine runs
package dlrpc_pkg;
    localparam int           NUM_CH      = 8;
    localparam int           DATA_W      = 16;
    localparam int           ADDR_W      = 5;
    localparam int           CH_IDX_W    = 3;
    // Address map: channels at 0x08..0x0F, command registers below
    localparam logic [4:0]   ADDR_CH_BASE = 5'h08;
    localparam logic [4:0]   ADDR_GPIO    = 5'h01;
    localparam logic [4:0]   ADDR_CORR    = 5'h02;
    localparam logic [15:0]  RESET_LOW    = 16'h0000;
    localparam logic [15:0]  RESET_MID    = 16'h8000;
    localparam logic [15:0]  TWOS_FLIP    = 16'h8000;
    localparam logic [15:0]  SB_ZERO      = 16'h0000;
    localparam int           CORR_TIME_NS = 400;
    localparam int           CLK_NS       = 10;
    localparam int           CORR_CYC     = (CORR_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int           CORR_W       = 6;

    typedef struct packed {
        logic              cs_n;
        logic              wr_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } dlrpc_wr_t;

    typedef struct packed {
        logic gpio_o;
        logic gpio_oe;
        logic busy_o;
        logic busy_oe;
    } dlrpc_od_t;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN} dlrpc_corr_t;
endpackage : dlrpc_pkg

// ==== dlrpc_corr.sv ====
// Correction engine timer that drives the busy indication
`timescale 1ns/10ps
module dlrpc_corr
    import dlrpc_pkg::*;
(
    input  wire logic clk,     // System clock
    input  wire logic rst_n,   // Sync reset, active low
    input  wire logic start,   // Kick one correction pass
    output logic      running  // High while pass runs
);
    dlrpc_corr_t       state_q, state_d;
    logic [CORR_W-1:0] cnt_q, cnt_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_RUN;
                    cnt_d   = CORR_W'(CORR_CYC - 1);
                end
            end
            ST_RUN: begin
                if (cnt_q == '0) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign running = (state_q == ST_RUN);
endmodule : dlrpc_corr

// ==== dlrpc_top.sv ====
// Pin control for load strobe, reset, clear, address and open-drain pins
`timescale 1ns/10ps
module dlrpc_top
    import dlrpc_pkg::*;
(
    input  wire logic                    clk,                 // 100 MHz clock
    input  wire logic                    rst_n,               // Sync reset, active low
    input  wire logic                    hw_reset_n,          // Hardware reset pin, active low
    input  wire logic                    latch_load_strobe_n, // Load strobe, active low
    input  wire logic                    output_clear_n,      // Clear pin, active low
    input  wire logic                    reset_level_select,  // 0 low scale, 1 midscale
    input  wire logic                    input_format_select, // 0 straight binary, 1 twos
    input  wire dlrpc_wr_t               wr,                  // Parallel write group
    input  wire logic                    gpio_i,              // Pin level seen
    output logic                         gpio_o,              // Always 0 when driving
    output logic                         gpio_oe,             // High pulls pin low
    output logic                         busy_o,              // Always 0 when driving
    output logic                         busy_oe,             // High while correcting
    output logic                         gpio_in_q,           // Sampled pin level
    output logic                         async_mode_q,        // Update mode caught at power-on
    output logic [NUM_CH-1:0]            out_connected_q,     // Output tied to amplifier
    output logic [NUM_CH*DATA_W-1:0]     converter_output_q   // Latched code per channel
);
    logic [DATA_W-1:0] data_reg_q [NUM_CH];
    logic [DATA_W-1:0] data_reg_d [NUM_CH];
    logic [DATA_W-1:0] latch_q    [NUM_CH];
    logic [DATA_W-1:0] latch_d    [NUM_CH];
    logic              gpio_drv_q, gpio_drv_d;
    logic              mode_caught_q, mode_caught_d;
    logic              async_d;
    logic              busy_drv_q;
    logic [NUM_CH-1:0] conn_d;
    logic              wr_en;
    logic              corr_start;
    logic              corr_run;

    function automatic logic [DATA_W-1:0] to_binary(input logic [DATA_W-1:0] v, input logic twos);
        to_binary = twos ? (v ^ TWOS_FLIP) : v;
    endfunction : to_binary

    function automatic logic [DATA_W-1:0] reset_code(input logic sel);
        reset_code = sel ? RESET_MID : RESET_LOW;
    endfunction : reset_code

    // Writes blocked under hardware reset so reset contents stay clean
    assign wr_en = !wr.cs_n && !wr.wr_n && hw_reset_n;
    assign corr_start = wr_en && (wr.addr == ADDR_CORR);

    dlrpc_corr u_corr (
        .clk     (clk),
        .rst_n   (rst_n),
        .start   (corr_start),
        .running (corr_run)
    );

    always_comb begin
        gpio_drv_d    = gpio_drv_q;
        mode_caught_d = 1'b1;
        // Strobe level caught once after reset release picks the mode
        async_d       = mode_caught_q ? async_mode_q : !latch_load_strobe_n;
        for (int i = 0; i < NUM_CH; i++) begin
            data_reg_d[i] = data_reg_q[i];
            latch_d[i]    = latch_q[i];
        end
        if (!hw_reset_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                data_reg_d[i] = reset_code(reset_level_select);
                latch_d[i]    = reset_code(reset_level_select);
            end
            gpio_drv_d = 1'b0;
        end else begin
            if (wr_en && wr.addr[4:3] == ADDR_CH_BASE[4:3]) begin
                data_reg_d[wr.addr[CH_IDX_W-1:0]] = to_binary(wr.data, input_format_select);
            end
            if (wr_en && wr.addr == ADDR_GPIO) begin
                // Command data is straight binary regardless of format pin
                gpio_drv_d = !wr.data[0];
            end
            if (!latch_load_strobe_n) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    latch_d[i] = data_reg_d[i];
                end
            end
        end
        for (int i = 0; i < NUM_CH; i++) begin
            conn_d[i] = output_clear_n && !latch_load_strobe_n;
        end
        if (!output_clear_n) begin
            conn_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                data_reg_q[i] <= RESET_LOW;
                latch_q[i]    <= RESET_LOW;
            end
            gpio_drv_q      <= 1'b0;
            mode_caught_q   <= 1'b0;
            async_mode_q    <= 1'b0;
            busy_drv_q      <= 1'b0;
            gpio_in_q       <= 1'b1;
            out_connected_q <= '0;
        end else begin
            data_reg_q      <= data_reg_d;
            latch_q         <= latch_d;
            gpio_drv_q      <= gpio_drv_d;
            mode_caught_q   <= mode_caught_d;
            async_mode_q    <= async_d;
            busy_drv_q      <= corr_run;
            gpio_in_q       <= gpio_i;
            out_connected_q <= conn_d;
        end
    end

    // Output code is the latch itself, so it moves exactly with the latch
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            converter_output_q[i*DATA_W +: DATA_W] = latch_q[i];
        end
    end

    assign gpio_o  = 1'b0;
    assign gpio_oe = gpio_drv_q;
    assign busy_o  = 1'b0;
    assign busy_oe = busy_drv_q;

    // Sampled rst_n in antecedents: disable iff sees a release one edge early
    AST_LATCH_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && hw_reset_n && !latch_load_strobe_n && $past(hw_reset_n)
        |=> latch_q[0] == $past(data_reg_d[0]))
        else $error("latch not transparent");
    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && hw_reset_n && latch_load_strobe_n |=> $stable(converter_output_q))
        else $error("output moved without load");
    AST_RESET_VAL: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && !hw_reset_n
        |=> data_reg_q[3] == reset_code($past(reset_level_select)) && latch_q[7] == data_reg_q[3])
        else $error("reset value wrong");
    AST_RESET_SEL: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && !hw_reset_n && reset_level_select |=> converter_output_q[DATA_W-1:0] == RESET_MID)
        else $error("midscale reset wrong");
    AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        !output_clear_n |=> out_connected_q == '0)
        else $error("clear did not ground outputs");
    AST_CONNECT: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && output_clear_n && !latch_load_strobe_n |=> &out_connected_q)
        else $error("outputs not connected");
    AST_TWOS: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && wr_en && wr.addr == ADDR_CH_BASE + 5'h01 && input_format_select
        |=> data_reg_q[1] == ($past(wr.data) ^ TWOS_FLIP))
        else $error("format conversion wrong");
    AST_NO_WR_IN_RST: assert property (@(posedge clk) disable iff (!rst_n)
        !hw_reset_n && !corr_run |=> !corr_run)
        else $error("write accepted in reset");
    AST_OD_GPIO: assert property (@(posedge clk) disable iff (!rst_n)
        gpio_oe |-> gpio_o == 1'b0)
        else $error("gpio driven high");
    AST_BUSY: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && corr_start && !corr_run |=> ##1 busy_oe [*8])
        else $error("busy not held");
    COV_LOAD: cover property (@(posedge clk) disable iff (!rst_n) !latch_load_strobe_n && wr_en);
    COV_RESET: cover property (@(posedge clk) disable iff (!rst_n) !hw_reset_n ##1 hw_reset_n);
    COV_BUSY: cover property (@(posedge clk) disable iff (!rst_n) busy_oe ##1 !busy_oe);
endmodule : dlrpc_top

// ==== dlrpc_host.sv ====
// Host model that drives the parallel write group and the hardware reset pin
`timescale 1ns/10ps
module dlrpc_host
    import dlrpc_pkg::*;
(
    input  wire logic clk,        // System clock
    output dlrpc_wr_t wr,         // Parallel write group
    output logic      hw_reset_n  // Hardware reset pin
);
    initial begin
        wr         = '{cs_n: 1'b1, wr_n: 1'b1, addr: 5'h00, data: 16'h0000};
        hw_reset_n = 1'b1;
    end
    // One word per edge, so calls placed back to back give back-to-back writes
    task automatic write(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= '{cs_n: 1'b0, wr_n: 1'b0, addr: a, data: d};
    endtask : write
    // Released lines show the inverse, so a stale copy cannot pass for data
    task automatic idle();
        @(posedge clk);
        wr <= '{cs_n: 1'b1, wr_n: 1'b1, addr: ~wr.addr, data: ~wr.data};
    endtask : idle
    task automatic hw_reset(input int n);
        @(posedge clk);
        wr.cs_n    <= 1'b1;
        hw_reset_n <= 1'b0;
        repeat (n) @(posedge clk);
        hw_reset_n <= 1'b1;
    endtask : hw_reset
    // Breaks the chip-select rule on purpose, to show writes are refused
    task automatic write_in_reset(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        wr         <= '{cs_n: 1'b0, wr_n: 1'b0, addr: a, data: d};
        hw_reset_n <= 1'b0;
        @(posedge clk);
        wr         <= '{cs_n: 1'b1, wr_n: 1'b1, addr: ~a, data: ~d};
        hw_reset_n <= 1'b1;
    endtask : write_in_reset
endmodule : dlrpc_host

// ==== dlrpc_tb_top.sv ====
// Self-checking testbench for the load, reset and pin control block
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module dlrpc_tb_top
    import dlrpc_pkg::*;
;
    logic                    clk, rst_n, strobe_n, clear_n, rsel, fmt, ext_pull_n, hw_reset_n;
    logic                    gpio_o, gpio_oe, busy_o, busy_oe, gpio_in_q, async_mode_q;
    logic [NUM_CH-1:0]       out_connected_q;
    logic [NUM_CH*DATA_W-1:0] conv_q;
    dlrpc_wr_t               wr;
    wire                     gpio_pin = (gpio_oe ? gpio_o : 1'b1) & ext_pull_n; // Pull-up
    int                      bad_count, cmp_count, n;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    dlrpc_host u_dlrpc_host (.clk(clk), .wr(wr), .hw_reset_n(hw_reset_n));
    dlrpc_top u_dlrpc_top (.clk(clk), .rst_n(rst_n), .hw_reset_n(hw_reset_n),
        .latch_load_strobe_n(strobe_n), .output_clear_n(clear_n), .reset_level_select(rsel),
        .input_format_select(fmt), .wr(wr), .gpio_i(gpio_pin), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
        .busy_o(busy_o), .busy_oe(busy_oe), .gpio_in_q(gpio_in_q), .async_mode_q(async_mode_q),
        .out_connected_q(out_connected_q), .converter_output_q(conv_q));

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic power_up(input logic lvl);
        @(posedge clk);
        rst_n    <= 1'b0;
        strobe_n <= lvl;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask : power_up
    task automatic chk_all(input logic [15:0] v);
        for (int i = 0; i < NUM_CH; i++) `CHK("code", v, conv_q[16*i +: 16])
    endtask : chk_all

    initial begin
        {rst_n, strobe_n, clear_n, rsel, fmt, ext_pull_n} = 6'b011001;
        power_up(1'b1);
        `CHK("async", 1'b0, async_mode_q)
        chk_all(RESET_LOW);
        power_up(1'b0);
        `CHK("async", 1'b1, async_mode_q)
        @(posedge clk);
        strobe_n <= 1'b1;
        u_dlrpc_host.write(ADDR_CH_BASE, 16'h1234);
        u_dlrpc_host.idle();
        repeat (2) @(posedge clk);
        #1 `CHK("held", 16'h0000, conv_q[15:0])
        @(posedge clk);
        strobe_n <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        #1 `CHK("load", 16'h1234, conv_q[15:0])
        `CHK("conn", 8'hFF, out_connected_q)
        for (int i = 0; i < NUM_CH; i++) u_dlrpc_host.write(ADDR_CH_BASE + 5'(i), 16'hA000 + 16'(i));
        u_dlrpc_host.write(5'h18, 16'hDEAD); // Differs from channel 0 only in bit 4
        u_dlrpc_host.idle();
        @(posedge clk);
        #1 for (int i = 0; i < NUM_CH; i++) `CHK("chan", 16'hA000 + 16'(i), conv_q[16*i +: 16])
        @(posedge clk);
        fmt <= 1'b1;
        u_dlrpc_host.write(ADDR_CH_BASE + 5'h07, 16'h0001);
        u_dlrpc_host.write(ADDR_CH_BASE + 5'h01, 16'hFFFF);
        u_dlrpc_host.idle();
        @(posedge clk);
        #1 `CHK("twos", 16'h8001, conv_q[127:112])
        `CHK("twos", 16'h7FFF, conv_q[31:16])
        @(posedge clk);
        fmt     <= 1'b0;
        clear_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK("clear", 8'h00, out_connected_q)
        @(posedge clk);
        clear_n <= 1'b1;
        rsel    <= 1'b1;
        u_dlrpc_host.hw_reset(3);
        @(posedge clk);
        #1 chk_all(RESET_MID);
        @(posedge clk);
        rsel <= 1'b0;
        u_dlrpc_host.hw_reset(3);
        @(posedge clk);
        #1 chk_all(RESET_LOW);
        // Correction start under reset must not run the engine
        u_dlrpc_host.write_in_reset(ADDR_CORR, 16'h0000);
        repeat (3) @(posedge clk);
        #1 `CHK("rstwr", 1'b0, busy_oe)
        u_dlrpc_host.write(ADDR_GPIO, 16'h0000);
        u_dlrpc_host.idle();
        repeat (2) @(posedge clk);
        #1 `CHK("gpio", 2'b10, {gpio_oe, gpio_o})
        `CHK("gpin", 1'b0, gpio_in_q)
        u_dlrpc_host.write(ADDR_GPIO, 16'h0001);
        u_dlrpc_host.idle();
        repeat (2) @(posedge clk);
        #1 `CHK("gpio", 1'b0, gpio_oe)
        `CHK("gpin", 1'b1, gpio_in_q)
        @(posedge clk);
        ext_pull_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK("gpin", 1'b0, gpio_in_q)
        @(posedge clk);
        ext_pull_n <= 1'b1;
        u_dlrpc_host.write(ADDR_CORR, 16'h0000);
        u_dlrpc_host.idle();
        n = 0;
        // Look just after each edge so the flop has settled
        for (int w = 0; w < 10 && busy_oe !== 1'b1; w++) begin
            @(posedge clk);
            #1;
        end
        `CHK("busy pin", 2'b10, {busy_oe, busy_o})
        for (int w = 0; w < 100 && busy_oe === 1'b1; w++) begin
            n++;
            @(posedge clk);
            #1;
        end
        `CHK("busy", CORR_CYC, n)
        tally_and_finish();
    end
    initial begin
        #20us;
        bad_count++;
        tally_and_finish();
    end
endmodule : dlrpc_tb_top
